// *** verilog/cmsld_pkg.sv ***
package cmsld_pkg;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_KHZ = 40000;
   localparam int T_ASSERT_MS = 200;
   localparam int T_RELEASE_MS = 3000;
   localparam int T_PW_IDLE_MS = 15000;
   localparam int T_WAKE_DISCH_MS = 2000;
   localparam int T_MODE_DISCH_MS = 100;
   localparam int ASSERT_CYC = T_ASSERT_MS * CLK_KHZ;
   localparam int RELEASE_CYC = T_RELEASE_MS * CLK_KHZ;
   localparam int PW_IDLE_CYC = T_PW_IDLE_MS * CLK_KHZ;
   localparam int WAKE_DISCH_CYC = T_WAKE_DISCH_MS * CLK_KHZ + 1;
   localparam int MODE_DISCH_CYC = T_MODE_DISCH_MS * CLK_KHZ;
   localparam int TIMER_W = 32;
   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
   localparam int CTRL_HID_BIT = 0;
   localparam int ST_MODE_LSB = 0;
   localparam int ST_PW_LSB = 4;
   localparam int ST_LD_BIT = 8;
   localparam int ST_DISCH_BIT = 9;
   localparam int ST_PORT_LSB = 12;
   localparam int ST_LPN_BIT = 17;
   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      MODE_DISCHARGE = 3'h0,
      MODE_AUTO = 3'h1,
      MODE_SHORTED = 3'h3,
      MODE_DIVIDER = 3'h2,
      MODE_STD_ONE = 3'h6,
      MODE_STD_TWO = 3'h7,
      MODE_DOWNSTREAM = 3'h5
   } cmsld_mode_t;
   typedef enum logic [1:0] {
      PW_CHARGE = 2'h0,
      PW_IDLE = 2'h1,
      PW_WAKE = 2'h3,
      PW_OFF = 2'h2
   } cmsld_pw_t;
   typedef struct packed {
      logic mode_sel_a;
      logic mode_sel_b;
      logic mode_sel_c;
      logic limit_select;
   } cmsld_pins_t;
   typedef struct packed {
      logic load_above;
      logic load_below;
      logic below_pw;
      logic pw_limit_hit;
      logic bc_primary;
      logic hid_present;
   } cmsld_sense_t;
   typedef struct packed {
      logic out_on;
      logic out_discharge;
      logic data_closed;
      logic high_current_limit;
      logic power_wake_limit;
   } cmsld_port_t;
   localparam cmsld_port_t PORT_RESET = 5'h08;
endpackage : cmsld_pkg

// *** verilog/cmsld_sync.sv ***
`timescale 1ns/1ps
module cmsld_sync
#(
   parameter int W = 10
)
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] stage;

   if (W < 1)
      $error("cmsld_sync: width must be at least 1");

   // Two flip-flop resynchroniser
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         stage <= '0;
         q <= '0;
      end
      else
      begin
         stage <= d;
         q <= stage;
      end
   end
endmodule : cmsld_sync

// *** verilog/cmsld_timer.sv ***
`timescale 1ns/1ps
module cmsld_timer
#(
   parameter int W = 32
)
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic run,
   input wire logic [W-1:0] limit,
   output logic done
);
   logic [W-1:0] count;

   if (W < 2)
      $error("cmsld_timer: width must be at least 2");

   // Counts while run holds, clears as soon as it drops
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         count <= '0;
      else if (!run)
         count <= '0;
      else if (count != limit)
         count <= count + {{(W-1){1'b0}}, 1'b1};
   end

   assign done = run && (count == limit);
endmodule : cmsld_timer

// *** verilog/cmsld_top.sv ***
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/1ps
// Notes on behaviour
// - Pins are watched continuously; all sixteen combinations pick a mode.
// - 000x discharge, 0x1x auto, x10x std one, 100/101 forced, 111 split.
// - Pins 100 lock shorted charging; limit select picks low or high.
// - Pins 101 lock divider charging; limit select picks low or high.
// - Auto mode: data switches open, high limit, detect only if select 1.
// - Code 1111: switches closed, high limit, load detection running.
// - Standard one: switches closed, limit from select, load flag idle.
// - Moving between 1111 and 1110 never discharges the output.
// - Power wake code swaps between wake limit and high limit.
// - Code 0111 uses the non power wake load thresholds.
// - Downstream mode flags load on thresholds or primary detection.
// - Covered mode changes are ignored while a HUMAN_INTERFACE_DEVICE device is present.
// - Power wake releases load flag when current stays under 45mA.
// - Load seen in power wake: flag on, output low 2s, then restored.
// - While charging in power wake the flag stays on, port watched.
// - No load in power wake: flag off, port watched for attach.
// - Flag on after 200ms above threshold, off after 3s below.
// - Under 45mA for 15s: wake limit applied and flag released.
// - Wake limit hit: flag on, discharge over 2s, then high limit.
// - Override holds the data mode on 111, 110 or 010 to 011.
module cmsld_top
#(
   parameter logic [31:0] ASSERT_CYC = 32'(cmsld_pkg::ASSERT_CYC),
   parameter logic [31:0] RELEASE_CYC = 32'(cmsld_pkg::RELEASE_CYC),
   parameter logic [31:0] PW_IDLE_CYC = 32'(cmsld_pkg::PW_IDLE_CYC),
   parameter logic [31:0] WAKE_DISCH_CYC =
      32'(cmsld_pkg::WAKE_DISCH_CYC),
   parameter logic [31:0] MODE_DISCH_CYC =
      32'(cmsld_pkg::MODE_DISCH_CYC)
)
(
   input wire logic mclk,
   input wire logic rst,
   input wire cmsld_pkg::cmsld_pins_t pins,
   input wire cmsld_pkg::cmsld_sense_t sense,
   output cmsld_pkg::cmsld_port_t port,
   output logic load_present_n,
   input wire logic [cmsld_pkg::ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   import cmsld_pkg::*;

   if (ASSERT_CYC < 32'h1 || RELEASE_CYC < 32'h1 || PW_IDLE_CYC < 32'h1 ||
       WAKE_DISCH_CYC < 32'h1 || MODE_DISCH_CYC < 32'h1)
      $error("cmsld_top: every duration needs at least one cycle");

   // ----------------------------------------------------------------
   // Input resynchronisation
   // ----------------------------------------------------------------
   cmsld_pins_t s_pins;
   cmsld_sense_t s_sense;

   // Pins and sense levels pass two flops before anything decodes them
   cmsld_sync #(.W(10)) u_sync
   (
      .mclk(mclk),
      .rst(rst),
      .d({pins, sense}),
      .q({s_pins, s_sense})
   );

   // ----------------------------------------------------------------
   // Mode decode
   // ----------------------------------------------------------------
   function automatic cmsld_mode_t decode_mode(input cmsld_pins_t p);
      logic [3:0] c;
      c = p;
      case (c[3:1])
         3'h0: decode_mode = MODE_DISCHARGE;
         3'h1, 3'h3: decode_mode = MODE_AUTO;
         3'h2, 3'h6: decode_mode = MODE_STD_ONE;
         3'h4: decode_mode = MODE_SHORTED;
         3'h5: decode_mode = MODE_DIVIDER;
         3'h7: decode_mode = c[0] ? MODE_DOWNSTREAM : MODE_STD_TWO;
         default: decode_mode = MODE_DISCHARGE;
      endcase
   endfunction : decode_mode

   cmsld_mode_t mode;
   cmsld_pw_t pw_state;
   cmsld_pw_t next_pw_state;
   logic [31:0] ctrl;
   logic disch_active;
   logic ld_flag;
   wire logic [2:0] code = {s_pins.mode_sel_a, s_pins.mode_sel_b,
                            s_pins.mode_sel_c};
   wire logic s_lim = s_pins.limit_select;
   wire cmsld_mode_t cmd_mode = decode_mode(s_pins);

   // Wake override: data mode kept when 011 is commanded with HUMAN_INTERFACE_DEVICE present
   wire logic data_mode = (mode == MODE_DOWNSTREAM) ||
                          (mode == MODE_STD_TWO) || (mode == MODE_STD_ONE);
   wire logic hid_block = ctrl[CTRL_HID_BIT] && s_sense.hid_present &&
                          data_mode && (code == 3'h3);
   wire logic mode_change = (cmd_mode != mode) && !disch_active &&
                            !hid_block;
   wire logic pair_move = ((mode == MODE_DOWNSTREAM) &&
                           (cmd_mode == MODE_STD_TWO)) ||
                          ((mode == MODE_STD_TWO) &&
                           (cmd_mode == MODE_DOWNSTREAM));

   // ----------------------------------------------------------------
   // Load detection qualifiers
   // ----------------------------------------------------------------
   wire logic pw_mode = (mode == MODE_AUTO) && (code == 3'h1) && s_lim;
   wire logic ld_on = ((mode == MODE_AUTO) && (code == 3'h3) && s_lim) ||
                      (mode == MODE_DOWNSTREAM);
   wire logic asrt_run = ld_on && !ld_flag && s_sense.load_above;
   wire logic rel_run = ld_on && ld_flag && s_sense.load_below;
   wire logic idle_run = (pw_state == PW_CHARGE) && s_sense.below_pw;
   wire logic wake_run = (pw_state == PW_WAKE);
   wire logic asrt_done;
   wire logic rel_done;
   wire logic idle_done;
   wire logic wake_done;
   wire logic disch_done;

   // Durations counted on the block clock
   cmsld_timer #(.W(TIMER_W)) u_asrt
   (
      .mclk(mclk), .rst(rst), .run(asrt_run), .limit(ASSERT_CYC),
      .done(asrt_done)
   );
   cmsld_timer #(.W(TIMER_W)) u_rel
   (
      .mclk(mclk), .rst(rst), .run(rel_run), .limit(RELEASE_CYC),
      .done(rel_done)
   );
   cmsld_timer #(.W(TIMER_W)) u_idle
   (
      .mclk(mclk), .rst(rst), .run(idle_run), .limit(PW_IDLE_CYC),
      .done(idle_done)
   );
   cmsld_timer #(.W(TIMER_W)) u_wake
   (
      .mclk(mclk), .rst(rst), .run(wake_run), .limit(WAKE_DISCH_CYC),
      .done(wake_done)
   );
   cmsld_timer #(.W(TIMER_W)) u_disch
   (
      .mclk(mclk), .rst(rst), .run(disch_active), .limit(MODE_DISCH_CYC),
      .done(disch_done)
   );

   // ----------------------------------------------------------------
   // Mode register and renegotiation discharge
   // ----------------------------------------------------------------
   // New mode taken; discharge runs except between the two 111 codes or when entering discharge mode
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         mode <= MODE_DISCHARGE;
         disch_active <= 1'b0;
      end
      else if (mode_change)
      begin
         mode <= cmd_mode;
         disch_active <= !pair_move && (cmd_mode != MODE_DISCHARGE);
      end
      else if (disch_done)
         disch_active <= 1'b0;
   end

   // ----------------------------------------------------------------
   // Load present flag, non power wake thresholds
   // ----------------------------------------------------------------
   wire logic bc_hit = (mode == MODE_DOWNSTREAM) && s_sense.bc_primary;
   wire logic next_ld_flag = !ld_on ? 1'b0 :
                             (asrt_done || bc_hit) ? 1'b1 :
                             rel_done ? 1'b0 : ld_flag;

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         ld_flag <= 1'b0;
      else
         ld_flag <= next_ld_flag;
   end

   // ----------------------------------------------------------------
   // Power wake state machine
   // ----------------------------------------------------------------
   always_comb
   begin
      next_pw_state = pw_state;
      case (pw_state)
         PW_OFF: next_pw_state = pw_mode ? PW_CHARGE : PW_OFF;
         PW_CHARGE: if (idle_done) next_pw_state = PW_IDLE;
         PW_IDLE: if (s_sense.pw_limit_hit) next_pw_state = PW_WAKE;
         PW_WAKE: if (wake_done) next_pw_state = PW_CHARGE;
         default: next_pw_state = PW_OFF;
      endcase
      if (!pw_mode)
         next_pw_state = PW_OFF;
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         pw_state <= PW_OFF;
      else
         pw_state <= next_pw_state;
   end

   // ----------------------------------------------------------------
   // Port outputs
   // ----------------------------------------------------------------
   wire logic hold_low = (mode == MODE_DISCHARGE) || disch_active ||
                         (pw_state == PW_WAKE);
   wire logic closed = (mode == MODE_STD_ONE) || (mode == MODE_STD_TWO) ||
                       (mode == MODE_DOWNSTREAM);
   wire logic use_pw_lim = pw_mode && (pw_state == PW_IDLE);
   wire logic use_high = (mode == MODE_AUTO) ? !use_pw_lim :
                         (mode == MODE_DOWNSTREAM) ? 1'b1 :
                         (mode == MODE_STD_TWO) ? 1'b0 :
                         s_lim;
   wire logic lp_on = pw_mode ? ((pw_state == PW_CHARGE) ||
                                 (pw_state == PW_WAKE)) :
                      (ld_flag && ld_on);
   wire cmsld_port_t next_port = '{
      out_on: !hold_low,
      out_discharge: hold_low,
      data_closed: closed && !hold_low,
      high_current_limit: use_high,
      power_wake_limit: use_pw_lim
   };

   // Outputs leave from flops; reset parks the port discharged
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         port <= PORT_RESET;
         load_present_n <= 1'b1;
      end
      else
      begin
         port <= next_port;
         load_present_n <= !lp_on;
      end
   end

   // ----------------------------------------------------------------
   // APB slave, no wait states
   // ----------------------------------------------------------------
   wire logic setup = psel && !penable;
   wire logic hit_ctrl = (paddr == ADDR_CTRL);
   wire logic hit_stat = (paddr == ADDR_STATUS);
   wire logic wr_ctrl = psel && penable && pready && pwrite && hit_ctrl;
   wire logic [31:0] status_word =
      (32'(mode) << ST_MODE_LSB) | (32'(pw_state) << ST_PW_LSB) |
      (32'(ld_flag) << ST_LD_BIT) | (32'(disch_active) << ST_DISCH_BIT) |
      (32'(port) << ST_PORT_LSB) | (32'(load_present_n) << ST_LPN_BIT);
   wire logic [31:0] rd_word = hit_ctrl ? ctrl :
                               hit_stat ? status_word : 32'h0000_0000;
   wire logic bad = !(hit_ctrl || (hit_stat && !pwrite));

   // Answer prepared in setup, presented through the access phase
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
      else
      begin
         pready <= setup;
         pslverr <= setup && bad;
         prdata <= (setup && !pwrite) ? rd_word : 32'h0000_0000;
      end
   end

   // Control word, only the override enable bit is kept
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         ctrl <= CTRL_RESET;
      else if (wr_ctrl)
         ctrl <= pwdata & CTRL_RESET;
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   chk_discharge_holds: assert property (
      @(posedge mclk) disable iff (rst)
      mode == MODE_DISCHARGE |=> !port.out_on && port.out_discharge)
      else $error("discharge mode left the output on");

   chk_forced_limit: assert property (
      @(posedge mclk) disable iff (rst)
      (mode == MODE_SHORTED || mode == MODE_DIVIDER)
      |=> port.high_current_limit == $past(s_lim))
      else $error("forced mode limit does not follow select");

   chk_auto_open: assert property (
      @(posedge mclk) disable iff (rst)
      mode == MODE_AUTO && pw_state != PW_IDLE
      |=> !port.data_closed && port.high_current_limit)
      else $error("auto mode switches or limit wrong");

   chk_downstream_port: assert property (
      @(posedge mclk) disable iff (rst)
      mode == MODE_DOWNSTREAM && !disch_active
      |=> port.data_closed && port.high_current_limit)
      else $error("downstream port not closed at high limit");

   chk_std_one_flag: assert property (
      @(posedge mclk) disable iff (rst)
      mode == MODE_STD_ONE |=> load_present_n)
      else $error("load flag active in standard port one");

   chk_pair_quiet: assert property (
      @(posedge mclk) disable iff (rst)
      ($past(mode) == MODE_DOWNSTREAM && mode == MODE_STD_TWO) ||
      ($past(mode) == MODE_STD_TWO && mode == MODE_DOWNSTREAM)
      |-> !disch_active)
      else $error("discharge between the two 111 codes");

   chk_hid_hold: assert property (
      @(posedge mclk) disable iff (rst)
      hid_block |=> mode == $past(mode))
      else $error("mode moved under the wake override");

   chk_pw_release: assert property (
      @(posedge mclk) disable iff (rst)
      pw_state == PW_IDLE && pw_mode
      |=> load_present_n && port.power_wake_limit)
      else $error("power wake idle keeps flag or limit");

   chk_wake_low: assert property (
      @(posedge mclk) disable iff (rst)
      $rose(pw_state == PW_WAKE) |=> (!port.out_on && !load_present_n)[*8])
      else $error("wake discharge not held");

   chk_flag_cause: assert property (
      @(posedge mclk) disable iff (rst)
      $rose(ld_flag) |-> $past(asrt_done) || $past(bc_hit))
      else $error("load flag rose without qualified load");
endmodule : cmsld_top

// *** test/cmsld_host_model.sv ***
`timescale 1ns/1ps
module cmsld_host_model
(
   input wire logic mclk,
   output cmsld_pkg::cmsld_pins_t pins,
   output cmsld_pkg::cmsld_sense_t sense
);
   import cmsld_pkg::*;
   // ----------------------------------------------------------------
   // Host control pins and port comparators
   // ----------------------------------------------------------------
   cmsld_pins_t pins_q;
   cmsld_sense_t sense_q;
   // Idle host: discharge code, no load on the port
   initial
   begin
      pins_q = '0;
      sense_q = '0;
   end
   // Pin and comparator levels move one edge after the host decides
   always_ff @(posedge mclk)
   begin
      pins <= pins_q;
      sense <= sense_q;
   end
   // Host picks a code just after an edge; the pins are plain levels
   task automatic set_code(input logic [3:0] code);
      @(posedge mclk);
      pins_q <= code;
   endtask : set_code
   // Load seen on the port, as comparator levels
   task automatic set_sense(input logic [5:0] s);
      @(posedge mclk);
      sense_q <= s;
   endtask : set_sense
endmodule : cmsld_host_model

// *** test/tb.sv ***
`timescale 1ns/1ps
module tb;
   import cmsld_pkg::*;
   localparam logic [7:0] ADDR_FREE = 8'h10;
   logic mclk;
   logic rst;
   cmsld_pins_t pins;
   cmsld_sense_t sense;
   cmsld_port_t port;
   logic load_present_n;
   logic [7:0] paddr;
   logic psel;
   logic penable;
   logic pwrite;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [31:0] rd;
   logic err;
   int failures;
   int checked;
   // ----------------------------------------------------------------
   // Instances
   // ----------------------------------------------------------------
   cmsld_host_model host (.mclk(mclk), .pins(pins), .sense(sense));
   cmsld_top #(.ASSERT_CYC(32'd10), .RELEASE_CYC(32'd20),
      .PW_IDLE_CYC(32'd30), .WAKE_DISCH_CYC(32'd15),
      .MODE_DISCH_CYC(32'd5)) dut (.mclk(mclk), .rst(rst), .pins(pins),
      .sense(sense), .port(port), .load_present_n(load_present_n),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Clock, 25 ns period
   initial
   begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   // Watchdog cuts a hang short
   initial
   begin
      repeat (20000) @(posedge mclk);
      failures++;
      test_done();
   end
   task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check_val
   task automatic check_bit(input logic got, input logic exp);
      check_val({31'h0, got}, {31'h0, exp});
   endtask : check_bit
   task automatic test_done;
      if (failures == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : test_done
   // One APB transfer; holds the request until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] wd);
      int n;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (n >= 50)
         failures++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Command a code and let sync, renegotiation and outputs settle
   task automatic go(input logic [3:0] c);
      host.set_code(c);
      repeat (20) @(negedge mclk);
   endtask : go
   // Expected {load_present_n, port} for each code with no load
   function automatic logic [5:0] exp_port(input logic [3:0] c);
      case (c[3:1])
         3'h0: return 6'h28;
         3'h1: return c[0] ? 6'h12 : 6'h32;
         3'h3: return 6'h32;
         3'h4, 3'h5: return {4'b1100, c[0], 1'b0};
         default: return {4'b1101, c[0], 1'b0};
      endcase
   endfunction : exp_port
   function automatic logic [2:0] exp_mode(input logic [3:0] c);
      case (c[3:1])
         3'h0: return 3'h0;
         3'h1, 3'h3: return 3'h1;
         3'h4: return 3'h3;
         3'h5: return 3'h2;
         3'h7: return c[0] ? 3'h5 : 3'h7;
         default: return 3'h6;
      endcase
   endfunction : exp_mode
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_table;
      logic [5:0] m;
      for (int i = 0; i < 16; i++)
      begin
         go(4'(i));
         m = (i < 2) ? 6'h3C : 6'h3F;
         check_val({26'h0, load_present_n, port} & m, exp_port(4'(i)) & m);
         apb(1'b0, ADDR_STATUS, 32'h0);
         check_val({29'h0, rd[2:0]}, {29'h0, exp_mode(4'(i))});
      end
   endtask : t_table
   task automatic t_no_disch;
      go(4'hF);
      host.set_code(4'hE);
      repeat (10)
      begin
         @(negedge mclk);
         check_bit(port.out_on, 1'b1);
      end
      check_bit(port.high_current_limit, 1'b0);
   endtask : t_no_disch
   task automatic t_load;
      go(4'h7);
      host.set_sense(6'h20);
      repeat (8) @(negedge mclk);
      check_bit(load_present_n, 1'b1);
      repeat (12) @(negedge mclk);
      check_bit(load_present_n, 1'b0);
      host.set_sense(6'h10);
      repeat (15) @(negedge mclk);
      check_bit(load_present_n, 1'b0);
      repeat (15) @(negedge mclk);
      check_bit(load_present_n, 1'b1);
      host.set_sense(6'h00);
      go(4'hF);
      host.set_sense(6'h02);
      repeat (6) @(negedge mclk);
      check_bit(load_present_n, 1'b0);
      host.set_sense(6'h00);
   endtask : t_load
   task automatic t_power_wake;
      go(4'h3);
      check_val({30'h0, load_present_n, port.high_current_limit}, 32'h1);
      host.set_sense(6'h08);
      repeat (45) @(negedge mclk);
      check_val({29'h0, load_present_n, port[1:0]}, 32'h5);
      check_bit(port.out_on, 1'b1);
      host.set_sense(6'h04);
      repeat (6) @(negedge mclk);
      check_val({30'h0, load_present_n, port.out_on}, 32'h0);
      host.set_sense(6'h00);
      repeat (8) @(negedge mclk);
      check_bit(port.out_on, 1'b0);
      repeat (16) @(negedge mclk);
      check_val({28'h0, load_present_n, port.out_on, port[1:0]}, 32'h6);
   endtask : t_power_wake
   task automatic t_hid;
      go(4'hF);
      host.set_sense(6'h01);
      repeat (4) @(negedge mclk);
      go(4'h7);
      check_bit(port.data_closed, 1'b1);
      apb(1'b1, ADDR_CTRL, 32'h0);
      apb(1'b0, ADDR_CTRL, 32'h0);
      check_val(rd, 32'h0);
      repeat (20) @(negedge mclk);
      check_bit(port.data_closed, 1'b0);
      host.set_sense(6'h00);
   endtask : t_hid
   task automatic t_apb_refuse;
      apb(1'b0, ADDR_FREE, 32'h0);
      check_val({31'h0, err}, 32'h1);
      check_val(rd, 32'h0);
      apb(1'b1, ADDR_STATUS, 32'hFFFF_FFFF);
      check_val({31'h0, err}, 32'h1);
   endtask : t_apb_refuse
   task automatic t_reset_checks;
      check_val({29'h0, port.out_on, port.data_closed, load_present_n}, 32'h1);
   endtask : t_reset_checks
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      failures = 0;
      checked = 0;
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      @(negedge mclk);
      t_reset_checks();
      apb(1'b0, ADDR_CTRL, 32'h0);
      check_val(rd, CTRL_RESET);
      t_table();
      t_no_disch();
      t_load();
      t_power_wake();
      t_hid();
      t_apb_refuse();
      go(4'hF);
      @(posedge mclk);
      rst <= 1'b1;
      repeat (2) @(negedge mclk);
      t_reset_checks();
      @(posedge mclk);
      rst <= 1'b0;
      repeat (2) @(negedge mclk);
      t_reset_checks();
      test_done();
   end
endmodule : tb
